// ---- pkg/cct_pkg.sv ----
// Constants, state layout and bus carrier of the calendar clock with trim.
// Assumes an 8-bit classic Wishbone slave port; register n sits at byte 4*n.
package cct_pkg;

    // ==============================================================
    // Register indices (byte address is four times the index)
    localparam logic [15:0] IDX_BT_ISEL = 16'hFE5F;
    localparam logic [15:0] IDX_BT_CTL  = 16'hFE7F;
    localparam logic [15:0] IDX_CAL_CTL = 16'hFEBA;
    localparam logic [15:0] IDX_SEC     = 16'hFEBB;
    localparam logic [15:0] IDX_MIN     = 16'hFEBC;
    localparam logic [15:0] IDX_HOUR    = 16'hFEBD;
    localparam logic [15:0] IDX_DNUM_LO = 16'hFEBE;
    localparam logic [15:0] IDX_DNUM_HI = 16'hFEBF;
    localparam logic [15:0] IDX_DOM     = 16'hFEC0;
    localparam logic [15:0] IDX_MON     = 16'hFEC1;
    localparam logic [15:0] IDX_YEAR    = 16'hFEC2;
    localparam logic [15:0] IDX_CENT    = 16'hFEC3;
    localparam logic [15:0] IDX_TRIM    = 16'hFEC4;
    localparam logic [15:0] IDX_PWR     = 16'hFEC5;

    // ==============================================================
    // Field positions
    localparam int CC_RUN    = 7;
    localparam int CC_REREAD = 6;
    localparam int CC_FLAG   = 5;
    localparam int CC_IEN    = 4;
    localparam int CC_PSEL   = 2;
    localparam int BT_ON     = 6;
    localparam int TRIM_FAST = 7;
    localparam int PWR_HKEEP = 2;

    // ==============================================================
    // Limits and reset values
    localparam logic [5:0] SEC_MAX  = 6'h3B;
    localparam logic [5:0] MIN_MAX  = 6'h3B;
    localparam logic [4:0] HOUR_MAX = 5'h17;
    localparam logic [3:0] MON_MAX  = 4'hC;
    localparam logic [6:0] YEAR_MAX = 7'h63;
    localparam logic [4:0] DOM_RST  = 5'h01;
    localparam logic [3:0] MON_RST  = 4'h1;
    localparam logic [7:0] REG_RST  = 8'h00;
    localparam logic [4:0] WIN_LAST = 5'h1D;

    // ==============================================================
    // Period select codes
    localparam logic [1:0] PS_SEC  = 2'h0;
    localparam logic [1:0] PS_MIN  = 2'h1;
    localparam logic [1:0] PS_HOUR = 2'h2;
    localparam logic [1:0] PS_DAY  = 2'h3;

    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [17:0] adr;
        logic        sel;
        logic [7:0]  dat;
    } cct_wb_req_t;

    typedef struct packed {
        logic [7:0]  isel;
        logic [7:0]  btctl;
        logic        run;
        logic        reread;
        logic        flag;
        logic        ien;
        logic [1:0]  psel;
        logic [1:0]  fix;
        logic [5:0]  sec;
        logic [5:0]  min;
        logic [4:0]  hour;
        logic [15:0] dnum;
        logic [4:0]  dom;
        logic [3:0]  mon;
        logic [6:0]  yr;
        logic [2:0]  cen;
        logic [7:0]  trim;
        logic        hkeep;
        logic [16:0] pre;
        logic [4:0]  win;
        logic        ack;
        logic [7:0]  dat;
        logic        irq;
        logic        wake;
    } cct_state_t;

endpackage

// ---- rtl/cct_calendar.sv ----
// Calendar clock with trimmed seconds, day number and interrupt period.
// Assumes subclk_tick is a one-cycle pulse per 32.768 kHz crystal period.
//
// Behaviour
// RL1: Calendar spans years 2000 to 2799, leap-aware.
// RL2: Separate unit counters chained by carries.
// RL3: Trim shifts rate about 0 to 129 ppm.
// RL4: Counting continues during crystal HOLD; here only while the PWR keep bit is set, otherwise ticks are frozen.
// RL5: Period interrupt only when enable is set.
// RL6: Power bit keeps clock alive, irq wakes.
// RL7: Software starts base timer on subclock first.
// RL8: Seconds loadable when stopped, live when running.
// RL9: Seconds count 0 to 59, carry out.
// RL10: Minutes count 0 to 59 on carry.
// RL11: Hours count 0 to 23 on carry.
// RL12: Sixteen-bit day number steps on hour carry.
// RL13: Stopping clears every counter register.
// RL14: Run bit starts and stops counting.
// RL15: Two-bit field picks interrupt interval.
// RL16: Flag sticky until cleared; flag+enable request.
// RL17: Day, month, year, century ranges and carries.
// RL18: One trimmed count pulse per nominal second.
`timescale 1ns/1ps
module cct_calendar
    import cct_pkg::*;
#(
    parameter int TICKS_PER_SEC = 32768
) (
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire cct_wb_req_t wb_req,
    output logic             wb_ack,
    output logic [7:0]       wb_dat_r,
    input  wire logic        subclk_tick,
    input  wire logic        hold_mode,
    output logic             irq_req,
    output logic             hold_release
);

    localparam logic [16:0] TPS = 17'(TICKS_PER_SEC);

    cct_state_t s_ff;
    cct_state_t nxt_s;

    // ==============================================================
    // Bus decode
    logic        req;
    logic        wr;
    logic [15:0] idx;
    logic [7:0]  wd;
    logic        ctl_wr;

    assign req    = wb_req.cyc & wb_req.stb & ~s_ff.ack;
    assign wr     = req & wb_req.we & wb_req.sel;
    assign idx    = wb_req.adr[17:2];
    assign wd     = wb_req.dat;
    assign ctl_wr = wr & (idx == IDX_CAL_CTL);

    // ==============================================================
    // Base timer tick and trimmed second
    logic        freeze;
    logic        tick;
    logic [16:0] len_m1;
    logic        sec_pulse;

    assign freeze = hold_mode & ~s_ff.hkeep; // RL6
    assign tick   = subclk_tick & s_ff.btctl[BT_ON] & ~freeze; // RL4

    // First second of each 30 s window is stretched or shrunk
    always_comb begin
        if (s_ff.win != 5'h00) begin
            len_m1 = TPS - 17'h00001;
        end else if (s_ff.trim[TRIM_FAST]) begin
            len_m1 = TPS - 17'h00001 - {10'h000, s_ff.trim[6:0]}; // RL3
        end else begin
            len_m1 = TPS - 17'h00001 + {10'h000, s_ff.trim[6:0]}; // RL3
        end
    end

    assign sec_pulse = s_ff.run & tick & (s_ff.pre == len_m1); // RL18

    // ==============================================================
    // Carry chain
    logic [4:0] dim;
    logic       leap;
    logic       c_sec;
    logic       c_min;
    logic       c_hour;
    logic       c_dom;
    logic       c_mon;
    logic       c_yr;
    logic       ev;

    // Year 2000+100c+y; century year leap only when c is a multiple of 4
    assign leap = (s_ff.yr[1:0] == 2'h0) &
                  ((s_ff.yr != 7'h00) | (s_ff.cen[1:0] == 2'h0)); // RL1

    always_comb begin
        unique case (s_ff.mon)
            4'h2:                      dim = leap ? 5'h1D : 5'h1C; // RL1
            4'h4, 4'h6, 4'h9, 4'hB:    dim = 5'h1E;
            default:                   dim = 5'h1F;
        endcase
    end

    assign c_sec  = sec_pulse & (s_ff.sec == SEC_MAX); // RL9
    assign c_min  = c_sec & (s_ff.min == MIN_MAX); // RL10
    assign c_hour = c_min & (s_ff.hour == HOUR_MAX); // RL11
    assign c_dom  = c_hour & (s_ff.dom >= dim); // RL17
    assign c_mon  = c_dom & (s_ff.mon >= MON_MAX); // RL17
    assign c_yr   = c_mon & (s_ff.yr >= YEAR_MAX); // RL17

    always_comb begin
        unique case (s_ff.psel)
            PS_SEC:  ev = sec_pulse; // RL15
            PS_MIN:  ev = c_sec; // RL15
            PS_HOUR: ev = c_min; // RL15
            PS_DAY:  ev = c_hour; // RL15
        endcase
    end

    // ==============================================================
    // Next state
    always_comb begin
        nxt_s     = s_ff;
        nxt_s.ack = req;

        // Register writes; counters only load while stopped
        if (wr) begin
            unique case (idx)
                IDX_BT_ISEL: nxt_s.isel = wd;
                IDX_BT_CTL:  nxt_s.btctl = wd;
                IDX_CAL_CTL: begin
                    nxt_s.run  = wd[CC_RUN]; // RL14
                    nxt_s.ien  = wd[CC_IEN];
                    nxt_s.psel = wd[CC_PSEL+1:CC_PSEL];
                    nxt_s.fix  = wd[1:0];
                    if (!wd[CC_REREAD]) begin
                        nxt_s.reread = 1'b0;
                    end
                    if (!wd[CC_FLAG]) begin
                        nxt_s.flag = 1'b0; // RL16
                    end
                end
                IDX_TRIM:    nxt_s.trim = wd;
                IDX_PWR:     nxt_s.hkeep = wd[PWR_HKEEP]; // RL6
                default: begin
                    if (!s_ff.run) begin
                        unique case (idx)
                            IDX_SEC:     nxt_s.sec = wd[5:0]; // RL8
                            IDX_MIN:     nxt_s.min = wd[5:0];
                            IDX_HOUR:    nxt_s.hour = wd[4:0];
                            IDX_DNUM_LO: nxt_s.dnum[7:0] = wd;
                            IDX_DNUM_HI: nxt_s.dnum[15:8] = wd;
                            IDX_DOM:     nxt_s.dom = wd[4:0];
                            IDX_MON:     nxt_s.mon = wd[3:0];
                            IDX_YEAR:    nxt_s.yr = wd[6:0];
                            IDX_CENT:    nxt_s.cen = wd[2:0];
                            default:     nxt_s.isel = s_ff.isel;
                        endcase
                    end
                end
            endcase
        end

        // Trim prescaler, held at zero while stopped
        if (!s_ff.run) begin
            nxt_s.pre = 17'h00000;
            nxt_s.win = 5'h00;
        end else if (tick) begin
            if (sec_pulse) begin
                nxt_s.pre = 17'h00000;
                nxt_s.win = (s_ff.win == WIN_LAST) ? 5'h00 : s_ff.win + 5'h01;
            end else begin
                nxt_s.pre = s_ff.pre + 17'h00001;
            end
        end

        // Counting chain
        if (sec_pulse) begin
            nxt_s.sec = c_sec ? 6'h00 : s_ff.sec + 6'h01; // RL9
        end
        if (c_sec) begin
            nxt_s.min = c_min ? 6'h00 : s_ff.min + 6'h01; // RL10
        end
        if (c_min) begin
            nxt_s.hour = c_hour ? 5'h00 : s_ff.hour + 5'h01; // RL11
        end
        if (c_hour) begin
            nxt_s.dnum = s_ff.dnum + 16'h0001; // RL12
            nxt_s.dom  = c_dom ? DOM_RST : s_ff.dom + 5'h01; // RL17
        end
        if (c_dom) begin
            nxt_s.mon = c_mon ? MON_RST : s_ff.mon + 4'h1; // RL2
        end
        if (c_mon) begin
            nxt_s.yr = c_yr ? 7'h00 : s_ff.yr + 7'h01; // RL2
        end
        if (c_yr) begin
            nxt_s.cen = s_ff.cen + 3'h1; // RL2
        end

        // Falling run clears every counter
        if (s_ff.run && !nxt_s.run) begin
            nxt_s.sec  = 6'h00; // RL13
            nxt_s.min  = 6'h00;
            nxt_s.hour = 5'h00;
            nxt_s.dnum = 16'h0000;
            nxt_s.dom  = 5'h00;
            nxt_s.mon  = 4'h0;
            nxt_s.yr   = 7'h00;
            nxt_s.cen  = 3'h0;
        end

        // Hardware set wins over a software clear
        if (ev) begin
            nxt_s.flag = 1'b1; // RL16
        end
        if (sec_pulse) begin
            nxt_s.reread = 1'b1;
        end

        nxt_s.irq  = nxt_s.flag & nxt_s.ien; // RL5
        nxt_s.wake = nxt_s.flag & nxt_s.ien; // RL6

        // Read data; unmapped reads zero
        nxt_s.dat = 8'h00;
        if (req && !wb_req.we) begin
            unique case (idx)
                IDX_BT_ISEL: nxt_s.dat = s_ff.isel;
                IDX_BT_CTL:  nxt_s.dat = s_ff.btctl;
                IDX_CAL_CTL: nxt_s.dat = {s_ff.run, s_ff.reread, s_ff.flag,
                                          s_ff.ien, s_ff.psel, s_ff.fix};
                IDX_SEC:     nxt_s.dat = {2'h0, s_ff.sec};
                IDX_MIN:     nxt_s.dat = {2'h0, s_ff.min};
                IDX_HOUR:    nxt_s.dat = {3'h0, s_ff.hour};
                IDX_DNUM_LO: nxt_s.dat = s_ff.dnum[7:0];
                IDX_DNUM_HI: nxt_s.dat = s_ff.dnum[15:8];
                IDX_DOM:     nxt_s.dat = {3'h0, s_ff.dom};
                IDX_MON:     nxt_s.dat = {4'h0, s_ff.mon};
                IDX_YEAR:    nxt_s.dat = {1'h0, s_ff.yr};
                IDX_CENT:    nxt_s.dat = {5'h00, s_ff.cen};
                IDX_TRIM:    nxt_s.dat = s_ff.trim;
                IDX_PWR:     nxt_s.dat = {5'h00, s_ff.hkeep, 2'h0};
                default:     nxt_s.dat = 8'h00;
            endcase
        end
    end

    // ==============================================================
    // State register
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            s_ff       <= '0;
            s_ff.isel  <= REG_RST;
            s_ff.btctl <= REG_RST;
            s_ff.trim  <= REG_RST;
            s_ff.dom   <= DOM_RST;
            s_ff.mon   <= MON_RST;
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign wb_ack       = s_ff.ack;
    assign wb_dat_r     = s_ff.dat;
    assign irq_req      = s_ff.irq;
    assign hold_release = s_ff.wake;

    // ==============================================================
    // Checks
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    sequence stop_seq;
        s_ff.run ##1 !s_ff.run;
    endsequence

    sequence sec_wrap_seq;
        sec_pulse && s_ff.sec == SEC_MAX;
    endsequence

    sequence day_step_seq;
        c_hour && nxt_s.run;
    endsequence

    sec_step_a: assert property (sec_pulse && s_ff.sec < SEC_MAX && nxt_s.run |=> // RL9
        s_ff.sec == $past(s_ff.sec) + 6'h01)
        else $error("seconds did not step");

    min_carry_a: assert property (sec_wrap_seq ##0 s_ff.min < MIN_MAX && nxt_s.run |=> // RL10
        s_ff.sec == 6'h00 && s_ff.min == $past(s_ff.min) + 6'h01)
        else $error("seconds wrap did not carry to minutes");

    hour_wrap_a: assert property (c_min && s_ff.hour == HOUR_MAX && nxt_s.run |=> // RL11
        s_ff.hour == 5'h00 && s_ff.min == 6'h00)
        else $error("hour did not wrap");

    day_number_a: assert property (day_step_seq |=> // RL12
        s_ff.dnum == $past(s_ff.dnum) + 16'h0001)
        else $error("day number did not step");

    dom_wrap_a: assert property (c_dom && nxt_s.run |=> // RL17
        s_ff.dom == DOM_RST)
        else $error("day of month did not wrap to one");

    feb_len_a: assert property (c_hour && s_ff.mon == 4'h2 && s_ff.dom == 5'h1C // RL1
        && !leap |-> c_dom)
        else $error("non-leap february not ended at 28");

    stop_clear_a: assert property (stop_seq |-> // RL13
        s_ff.sec == 6'h00 && s_ff.dnum == 16'h0000 && s_ff.mon == 4'h0)
        else $error("counters not cleared on stop");

    load_sec_a: assert property (wr && idx == IDX_SEC && !s_ff.run |=> // RL8
        s_ff.sec == $past(wd[5:0]))
        else $error("seconds load failed");

    run_bit_a: assert property (ctl_wr |=> s_ff.run == $past(wd[CC_RUN])) // RL14
        else $error("run bit not taken");

    flag_hold_a: assert property (s_ff.flag && !ctl_wr |=> s_ff.flag) // RL16
        else $error("flag dropped without a clear");

    period_min_a: assert property (s_ff.psel == PS_MIN && c_sec |=> s_ff.flag) // RL15
        else $error("minute period did not set flag");

    irq_gate_a: assert property (s_ff.flag && s_ff.ien |-> irq_req && // RL5
        hold_release)
        else $error("interrupt request missing");

    no_irq_a: assert property (!nxt_s.ien |=> !irq_req) // RL5
        else $error("interrupt without enable");

    hold_freeze_a: assert property (hold_mode && !s_ff.hkeep |-> !sec_pulse) // RL6
        else $error("counting in hold without keep bit");

    hold_count_a: assert property (hold_mode && s_ff.hkeep && s_ff.run && // RL4
        subclk_tick && s_ff.btctl[BT_ON] && !sec_pulse && nxt_s.run |=>
        s_ff.pre == $past(s_ff.pre) + 17'h00001)
        else $error("prescaler stalled in hold");

    trim_len_a: assert property (s_ff.win == 5'h00 && s_ff.run && // RL3
        s_ff.trim[TRIM_FAST] |-> len_m1 < TPS - 17'h00001 ||
        s_ff.trim[6:0] == 7'h00)
        else $error("fast trim did not shorten the second");

    sec_live_a: assert property (wr && idx == IDX_SEC && s_ff.run && !sec_pulse |=> // RL8
        s_ff.sec == $past(s_ff.sec))
        else $error("seconds written while running");

    year_carry_a: assert property (c_yr && nxt_s.run |=> // RL2
        s_ff.yr == 7'h00 && s_ff.cen == $past(s_ff.cen) + 3'h1)
        else $error("year wrap did not carry to century");

    mon_wrap_a: assert property (c_mon && nxt_s.run |=> // RL17
        s_ff.mon == MON_RST)
        else $error("month did not wrap to one");

    dom_step_a: assert property (day_step_seq ##0 !c_dom |=> // RL17
        s_ff.dom == $past(s_ff.dom) + 5'h01)
        else $error("day of month did not step");

    period_day_a: assert property (s_ff.psel == PS_DAY && c_hour |=> // RL15
        s_ff.flag)
        else $error("day period did not set flag");

    stop_idle_a: assert property (!s_ff.run |=> // RL14
        s_ff.pre == 17'h00000 && s_ff.win == 5'h00)
        else $error("prescaler moved while stopped");

endmodule // cct_calendar

// ---- testbench/calendar_clock_with_trim_tb.sv ----
// Self-checking bench for the calendar clock with trim.
// Assumes cct_calendar and cct_pkg; a second is shortened to TPS subclock ticks.
`timescale 1ns/1ps
module calendar_clock_with_trim_tb;
    import cct_pkg::*;
    localparam int TPS = 8;
    logic        sys_clk;
    logic        rst;
    cct_wb_req_t wb_req;
    logic        wb_ack;
    logic [7:0]  wb_dat_r;
    logic        subclk_tick;
    logic        hold_mode;
    logic        irq_req;
    logic        hold_release;
    int          failures;
    int          n_compared;
    logic [7:0]  rd;

    cct_calendar #(.TICKS_PER_SEC(TPS)) dut (
        .sys_clk      (sys_clk),
        .rst          (rst),
        .wb_req       (wb_req),
        .wb_ack       (wb_ack),
        .wb_dat_r     (wb_dat_r),
        .subclk_tick  (subclk_tick),
        .hold_mode    (hold_mode),
        .irq_req      (irq_req),
        .hold_release (hold_release)
    );

    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    // ==============================================================
    // Compare and bus tasks
    task automatic check8(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic check1(input logic got, input logic exp);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wb_cycle(input logic we, input logic [15:0] idx, input logic [7:0] wd,
                            output logic [7:0] q);
        int n;
        @(posedge sys_clk);
        wb_req <= '{cyc:1'b1, stb:1'b1, we:we, adr:{idx, 2'b00}, sel:1'b1, dat:wd};
        q = 8'h00;
        for (n = 0; n < 20; n++) begin
            @(posedge sys_clk);
            if (wb_ack === 1'b1) begin
                q = wb_dat_r;
                break;
            end
        end
        if (n == 20) begin
            failures++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
        end
        wb_req <= '0;
    endtask

    task automatic wr(input logic [15:0] idx, input logic [7:0] d);
        wb_cycle(1'b1, idx, d, rd);
    endtask

    task automatic chk_reg(input logic [15:0] idx, input logic [7:0] exp);
        wb_cycle(1'b0, idx, 8'h00, rd);
        check8(rd, exp);
    endtask

    task automatic ticks(input int n);
        repeat (n) begin
            @(posedge sys_clk);
            subclk_tick <= 1'b1;
            @(posedge sys_clk);
            subclk_tick <= 1'b0;
        end
        repeat (3) @(posedge sys_clk);
    endtask

    // Stops the calendar, then loads sec, min, hour, day number, dom, month, year, century
    task automatic load(input logic [7:0] s, m, h, dl, dh, dm, mo, y, c);
        wr(IDX_CAL_CTL, 8'h00);
        wr(IDX_SEC, s);
        wr(IDX_MIN, m);
        wr(IDX_HOUR, h);
        wr(IDX_DNUM_LO, dl);
        wr(IDX_DNUM_HI, dh);
        wr(IDX_DOM, dm);
        wr(IDX_MON, mo);
        wr(IDX_YEAR, y);
        wr(IDX_CENT, c);
    endtask

    // ==============================================================
    // Scenarios
    task automatic test_reset;
        chk_reg(IDX_CAL_CTL, 8'h00);
        chk_reg(IDX_BT_CTL, 8'h00);
        chk_reg(IDX_DNUM_HI, 8'h00);
        chk_reg(IDX_DOM, 8'h01);
        chk_reg(IDX_MON, 8'h01);
        chk_reg(IDX_TRIM, 8'h00);
        chk_reg(16'h0000, 8'h00);
        wr(IDX_BT_ISEL, 8'hA5);
        chk_reg(IDX_BT_ISEL, 8'hA5);
        $display("test_reset done");
    endtask

    task automatic test_carry;
        wr(IDX_BT_CTL, 8'h40);
        load(8'h3B, 8'h3B, 8'h17, 8'hFF, 8'h00, 8'h1F, 8'h0C, 8'h63, 8'h00);
        wr(IDX_CAL_CTL, 8'h9C);
        wr(IDX_SEC, 8'h05);
        ticks(TPS);
        chk_reg(IDX_SEC, 8'h00);
        chk_reg(IDX_MIN, 8'h00);
        chk_reg(IDX_HOUR, 8'h00);
        chk_reg(IDX_DNUM_LO, 8'h00);
        chk_reg(IDX_DNUM_HI, 8'h01);
        chk_reg(IDX_DOM, 8'h01);
        chk_reg(IDX_MON, 8'h01);
        chk_reg(IDX_YEAR, 8'h00);
        chk_reg(IDX_CENT, 8'h01);
        chk_reg(IDX_CAL_CTL, 8'hFC);
        check1(irq_req, 1'b1);
        check1(hold_release, 1'b1);
        wr(IDX_CAL_CTL, 8'h1C);
        chk_reg(IDX_DNUM_HI, 8'h00);
        chk_reg(IDX_DOM, 8'h00);
        chk_reg(IDX_MON, 8'h00);
        chk_reg(IDX_CENT, 8'h00);
        check1(irq_req, 1'b0);
        $display("test_carry done");
    endtask

    task automatic test_period;
        for (int p = 0; p < 4; p++) begin
            load(8'h3B, 8'h3B, 8'h0A, 8'h00, 8'h00, 8'h01, 8'h01, 8'h00, 8'h00);
            wr(IDX_CAL_CTL, 8'h90 | 8'(p << 2));
            ticks(TPS);
            check1(irq_req, p != 3);
            check1(hold_release, p != 3);
        end
        $display("test_period done");
    endtask

    task automatic leap(input logic [7:0] c, input logic [7:0] dm, input logic [7:0] mo);
        load(8'h3B, 8'h3B, 8'h17, 8'h00, 8'h00, 8'h1C, 8'h02, 8'h00, c);
        wr(IDX_CAL_CTL, 8'h80);
        ticks(TPS);
        chk_reg(IDX_DOM, dm);
        chk_reg(IDX_MON, mo);
        chk_reg(IDX_CAL_CTL, 8'hE0);
        check1(irq_req, 1'b0);
    endtask

    task automatic test_leap;
        leap(8'h00, 8'h1D, 8'h02);
        leap(8'h01, 8'h01, 8'h03);
        $display("test_leap done");
    endtask

    task automatic trim(input logic [7:0] t, input int n);
        load(8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h00, 8'h00);
        wr(IDX_TRIM, t);
        wr(IDX_CAL_CTL, 8'h80);
        ticks(n - 1);
        chk_reg(IDX_SEC, 8'h00);
        ticks(1);
        chk_reg(IDX_SEC, 8'h01);
    endtask

    task automatic test_trim;
        trim(8'h82, TPS - 2);
        trim(8'h03, TPS + 3);
        trim(8'h00, TPS);
        $display("test_trim done");
    endtask

    task automatic test_hold;
        load(8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h00, 8'h00);
        @(posedge sys_clk);
        hold_mode <= 1'b1;
        wr(IDX_PWR, 8'h00);
        wr(IDX_CAL_CTL, 8'h80);
        ticks(TPS);
        chk_reg(IDX_SEC, 8'h00);
        wr(IDX_PWR, 8'h04);
        ticks(TPS);
        chk_reg(IDX_SEC, 8'h01);
        hold_mode <= 1'b0;
        $display("test_hold done");
    endtask

    // ==============================================================
    // Verdict
    task automatic report_and_stop;
        $display("compared=%0d failures=%0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    initial begin
        #400000;
        failures++;
        report_and_stop();
    end

    initial begin
        failures = 0;
        n_compared = 0;
        wb_req = '0;
        subclk_tick = 1'b0;
        hold_mode = 1'b0;
        rst = 1'b1;
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        test_reset();
        test_carry();
        test_period();
        test_leap();
        test_trim();
        test_hold();
        report_and_stop();
    end
endmodule // calendar_clock_with_trim_tb
